// *** design/cmxl_regs.v ***
// What this block does
// - Mid strap: low-Z bits 1, primary 0
// - Strap 0/1: low-Z bits 0, primary from strap
// - Low-Z bit 1 gives 34 ohm
// - Slew default from strap, or forced fast
// - Slew bit writable; 0 slow, 1 fast
// - Both-low detect shuts input receiver when enabled
// - Reserved low-low field resets 0x12, writable
// - Per-input bias enable, reset 0
// - Per-input termination enable, reset 0
// - Permanent guard set blocks control writes
// - Permanent guard cleared only by power
// - Writing 1 sets clearable guard
// - Clearable guard cleared by writing 1
// - Input 1 loss sets sticky bit 2
// - Input 0 loss sets sticky bit 1
// - Write 1 clears loss flag, 0 nothing
// - Primary bit: 0 is 85, 1 is 100
// - Live presence bits readable, feed flags
`timescale 1ns/1ps
`include "cmxl_defs.vh"

module cmxl_regs (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Register access from the serial engine
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata_reg,
	output reg         reg_wr_discarded_reg,
	output reg         init_done_out_reg,
	// Straps
	input  wire        impedance_strap_mid,
	input  wire        impedance_strap_high,
	input  wire        slew_strap_pin,
	input  wire        startup_force_fast,
	// Reference inputs
	input  wire        ref_input0_true_low,
	input  wire        ref_input0_comp_low,
	input  wire        ref_input1_true_low,
	input  wire        ref_input1_comp_low,
	input  wire        input0_present_live,
	input  wire        input1_present_live,
	// Analog controls
	output reg  [7:0]  out_low_z_select_reg,
	output reg  [7:0]  out_primary_z_select_reg,
	output reg  [15:0] out_z_code_reg,
	output reg  [7:0]  out_edge_speed_reg,
	output reg         input0_rx_off_reg,
	output reg         input1_rx_off_reg,
	output reg         input0_internal_bias_en_reg,
	output reg         input1_internal_bias_en_reg,
	output reg         input0_termination_en_reg,
	output reg         input1_termination_en_reg,
	output reg         write_locked_reg
);
	reg  [7:0]  primary_z_reg;
	reg  [7:0]  low_z_reg;
	reg  [7:0]  slew_reg;
	reg  [7:0]  both_low_reg;
	reg  [7:0]  rx_config_reg;
	reg  [7:0]  perm_guard_reg;
	reg         clr_guard_reg;
	reg  [7:0]  rdata_next;
	reg  [15:0] z_code_next;
	wire        load_pulse;
	wire        init_done;
	wire [7:0]  low_z_default;
	wire [7:0]  primary_default;
	wire [7:0]  slew_default;
	wire        loss0_flag;
	wire        loss1_flag;
	wire        locked;
	wire        ctrl_wr;
	wire        evt_wr;
	integer     i;

	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	function [1:0] z_code;
		input low_z;
		input primary;
		begin
			if (low_z)
				z_code = `CMXL_Z_34;
			else if (primary)
				z_code = `CMXL_Z_100;
			else
				z_code = `CMXL_Z_85;
		end
	endfunction

	cmxl_strap_init u_strap (
		.clk                (clk),
		.rst                (rst),
		.strap_z_mid        (impedance_strap_mid),
		.strap_z_high       (impedance_strap_high),
		.strap_slew         (slew_strap_pin),
		.startup_force_fast (startup_force_fast),
		.load_pulse         (load_pulse),
		.low_z_default      (low_z_default),
		.primary_default    (primary_default),
		.slew_default       (slew_default),
		.init_done_reg      (init_done)
	);

	assign locked  = perm_guard_reg[`CMXL_BIT_GUARD] | clr_guard_reg;
	assign ctrl_wr = reg_wr & ~locked & ~load_pulse;
	assign evt_wr  = reg_wr & hit(reg_addr, `CMXL_OFS_EVENTS);

	cmxl_loss_flag u_loss0 (
		.clk          (clk),
		.rst          (rst),
		.present_live (input0_present_live),
		.clear_pulse  (evt_wr & reg_wdata[`CMXL_BIT_LOSS0]),
		.flag_reg     (loss0_flag)
	);

	cmxl_loss_flag u_loss1 (
		.clk          (clk),
		.rst          (rst),
		.present_live (input1_present_live),
		.clear_pulse  (evt_wr & reg_wdata[`CMXL_BIT_LOSS1]),
		.flag_reg     (loss1_flag)
	);

	// Control registers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			primary_z_reg  <= `CMXL_RST_PRIMARY_Z;
			low_z_reg      <= `CMXL_RST_LOW_Z;
			slew_reg       <= `CMXL_RST_SLEW;
			both_low_reg   <= `CMXL_RST_BOTH_LOW;
			rx_config_reg  <= `CMXL_RST_RX_CONFIG;
			perm_guard_reg <= `CMXL_RST_PERM_GUARD;
			clr_guard_reg  <= 1'b0;
		end else begin
			if (load_pulse) begin
				low_z_reg     <= low_z_default;
				primary_z_reg <= primary_default;
				slew_reg      <= slew_default;
			end
			if (ctrl_wr) begin
				if (hit(reg_addr, `CMXL_OFS_PRIMARY_Z))
					primary_z_reg <= reg_wdata;
				if (hit(reg_addr, `CMXL_OFS_LOW_Z))
					low_z_reg <= reg_wdata;
				if (hit(reg_addr, `CMXL_OFS_SLEW))
					slew_reg <= reg_wdata;
				if (hit(reg_addr, `CMXL_OFS_BOTH_LOW))
					both_low_reg <= reg_wdata;
				if (hit(reg_addr, `CMXL_OFS_RX_CONFIG))
					rx_config_reg <= reg_wdata;
				// No write drops the guard bit once set
				if (hit(reg_addr, `CMXL_OFS_PERM_GUARD))
					perm_guard_reg <= {reg_wdata[7:1], perm_guard_reg[0] | reg_wdata[0]};
			end
			// Writing 1 flips it: sets when clear, clears when set, whatever the permanent guard holds
			if (evt_wr & reg_wdata[`CMXL_BIT_GUARD])
				clr_guard_reg <= ~clr_guard_reg;
		end
	end

	// Read mux
	always @* begin
		rdata_next = 8'h00;
		case (reg_addr)
			`CMXL_OFS_LIVE_STATUS: rdata_next = {6'h00, input1_present_live, input0_present_live};
			`CMXL_OFS_PRIMARY_Z:   rdata_next = primary_z_reg;
			`CMXL_OFS_LOW_Z:       rdata_next = low_z_reg;
			`CMXL_OFS_SLEW:        rdata_next = slew_reg;
			`CMXL_OFS_BOTH_LOW:    rdata_next = both_low_reg;
			`CMXL_OFS_RX_CONFIG:   rdata_next = rx_config_reg;
			`CMXL_OFS_PERM_GUARD:  rdata_next = perm_guard_reg;
			`CMXL_OFS_EVENTS:      rdata_next = {5'h00, loss1_flag, loss0_flag, clr_guard_reg};
			default:               rdata_next = 8'h00;
		endcase
	end

	always @* begin
		z_code_next = 16'h0000;
		for (i = 0; i < 8; i = i + 1)
			z_code_next[2*i +: 2] = z_code(low_z_reg[i], primary_z_reg[i]);
	end

	// Outputs, all registered
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_reg               <= 8'h00;
			reg_wr_discarded_reg        <= 1'b0;
			init_done_out_reg           <= 1'b0;
			out_low_z_select_reg        <= `CMXL_RST_LOW_Z;
			out_primary_z_select_reg    <= `CMXL_RST_PRIMARY_Z;
			out_z_code_reg              <= 16'haaaa;
			out_edge_speed_reg          <= `CMXL_RST_SLEW;
			input0_rx_off_reg           <= 1'b0;
			input1_rx_off_reg           <= 1'b0;
			input0_internal_bias_en_reg <= 1'b0;
			input1_internal_bias_en_reg <= 1'b0;
			input0_termination_en_reg   <= 1'b0;
			input1_termination_en_reg   <= 1'b0;
			write_locked_reg            <= 1'b0;
		end else begin
			if (reg_rd)
				reg_rdata_reg <= rdata_next;
			reg_wr_discarded_reg        <= reg_wr & locked & ~evt_wr;
			init_done_out_reg           <= init_done;
			out_low_z_select_reg        <= low_z_reg;
			out_primary_z_select_reg    <= primary_z_reg;
			out_z_code_reg              <= z_code_next;
			out_edge_speed_reg          <= slew_reg;
			input0_rx_off_reg           <= both_low_reg[`CMXL_BIT_BOTH_LOW_EN] &
				ref_input0_true_low & ref_input0_comp_low;
			input1_rx_off_reg           <= both_low_reg[`CMXL_BIT_BOTH_LOW_EN] &
				ref_input1_true_low & ref_input1_comp_low;
			input0_internal_bias_en_reg <= rx_config_reg[`CMXL_BIT_BIAS0];
			input1_internal_bias_en_reg <= rx_config_reg[`CMXL_BIT_BIAS1];
			input0_termination_en_reg   <= rx_config_reg[`CMXL_BIT_TERM0];
			input1_termination_en_reg   <= rx_config_reg[`CMXL_BIT_TERM1];
			write_locked_reg            <= locked;
		end
	end
endmodule // cmxl_regs

// *** design/cmxl_defs.vh ***
`ifndef CMXL_DEFS_VH
`define CMXL_DEFS_VH

// Register offsets
`define CMXL_OFS_LIVE_STATUS   8'h13
`define CMXL_OFS_PRIMARY_Z     8'h14
`define CMXL_OFS_LOW_Z         8'h15
`define CMXL_OFS_SLEW          8'h16
`define CMXL_OFS_BOTH_LOW      8'h17
`define CMXL_OFS_RX_CONFIG     8'h18
`define CMXL_OFS_PERM_GUARD    8'h19
`define CMXL_OFS_EVENTS        8'h1a

// Reset values
`define CMXL_RST_PRIMARY_Z     8'h00
`define CMXL_RST_LOW_Z         8'hff
`define CMXL_RST_SLEW          8'hff
`define CMXL_RST_BOTH_LOW      8'h94
`define CMXL_RST_RX_CONFIG     8'h00
`define CMXL_RST_PERM_GUARD    8'h00
`define CMXL_RST_EVENTS        8'h00

// Field positions
`define CMXL_BIT_BOTH_LOW_EN   2
`define CMXL_BIT_TERM0         0
`define CMXL_BIT_BIAS0         1
`define CMXL_BIT_TERM1         2
`define CMXL_BIT_BIAS1         3
`define CMXL_BIT_GUARD         0
`define CMXL_BIT_LOSS0         1
`define CMXL_BIT_LOSS1         2
`define CMXL_BIT_LIVE0         0
`define CMXL_BIT_LIVE1         1

// Per-output impedance codes
`define CMXL_Z_85              2'h0
`define CMXL_Z_100             2'h1
`define CMXL_Z_34              2'h2

`endif

// *** design/cmxl_strap_init.v ***
`timescale 1ns/1ps
`include "cmxl_defs.vh"

module cmxl_strap_init (
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Strap levels
	input  wire       strap_z_mid,
	input  wire       strap_z_high,
	input  wire       strap_slew,
	input  wire       startup_force_fast,
	// Loaded defaults
	output wire       load_pulse,
	output wire [7:0] low_z_default,
	output wire [7:0] primary_default,
	output wire [7:0] slew_default,
	output reg        init_done_reg
);
	// Straps are sampled on the first edge after reset release, never by the reset itself
	always @(posedge clk or posedge rst) begin
		if (rst)
			init_done_reg <= 1'b0;
		else
			init_done_reg <= 1'b1;
	end

	assign load_pulse      = ~init_done_reg;
	assign low_z_default   = {8{strap_z_mid}};
	assign primary_default = {8{~strap_z_mid & strap_z_high}};
	assign slew_default    = startup_force_fast ? 8'hff : {8{strap_slew}};
endmodule // cmxl_strap_init

// *** design/cmxl_loss_flag.v ***
`timescale 1ns/1ps

module cmxl_loss_flag (
	// Clock and reset
	input  wire clk,
	input  wire rst,
	// Detector and clear
	input  wire present_live,
	input  wire clear_pulse,
	// Flag
	output reg  flag_reg
);
	reg present_prev_reg;
	wire loss_event;

	// Starts as absent, so an input never seen is no event
	assign loss_event = present_prev_reg & ~present_live;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			present_prev_reg <= 1'b0;
			flag_reg         <= 1'b0;
		end else begin
			present_prev_reg <= present_live;
			if (loss_event)
				flag_reg <= 1'b1;
			else if (clear_pulse)
				flag_reg <= 1'b0;
		end
	end
endmodule // cmxl_loss_flag

// *** sim/cmxl_host.sv ***
`timescale 1ns/1ps

module cmxl_host (
	// Clock and read data
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata_reg,
	// Request side
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// Idle bus shows inverted values, never the stale byte
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		q = reg_rdata_reg;
	endtask
endmodule // cmxl_host

// *** sim/cmxl_regs_assertions.sv ***
`timescale 1ns/1ps

module cmxl_regs_chk (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Register port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata_reg,
	input wire logic        reg_wr_discarded_reg,
	input wire logic        init_done_out_reg,
	// Controls
	input wire logic [7:0]  out_low_z_select_reg,
	input wire logic [7:0]  out_primary_z_select_reg,
	input wire logic [15:0] out_z_code_reg,
	input wire logic [7:0]  out_edge_speed_reg,
	input wire logic        input0_rx_off_reg,
	input wire logic        input0_internal_bias_en_reg,
	input wire logic        input1_internal_bias_en_reg,
	input wire logic        input0_termination_en_reg,
	input wire logic        input1_termination_en_reg,
	input wire logic        write_locked_reg
);
	logic [15:0] zexp;
	always_comb
		for (int i = 0; i < 8; i++)
			zexp[2*i+:2] = out_low_z_select_reg[i] ? 2'h2 : {1'b0, out_primary_z_select_reg[i]};

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	z_code_map_a: assert property (out_z_code_reg == zexp)
		else $error("impedance code mismatch");
	discard_on_lock_a: assert property (write_locked_reg ##1 (write_locked_reg && reg_wr && reg_addr != 8'h1a)
		|-> ##[1:2] reg_wr_discarded_reg) else $error("locked write not discarded");
	discard_cause_a: assert property (reg_wr_discarded_reg |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("discard without write");
	unlock_cause_a: assert property ($fell(write_locked_reg) |-> ($past(reg_wr) && $past(reg_addr) == 8'h1a)
		|| ($past(reg_wr, 2) && $past(reg_addr, 2) == 8'h1a)) else $error("lock dropped without clear");
	locked_hold_a: assert property (write_locked_reg ##1 write_locked_reg
		|-> $stable(out_edge_speed_reg) && $stable(out_low_z_select_reg)) else $error("control changed while locked");
	slew_write_a: assert property (init_done_out_reg && reg_wr && reg_addr == 8'h16 ##1 !write_locked_reg
		|=> out_edge_speed_reg == $past(reg_wdata, 2)) else $error("slew write lost");
	rx_cfg_a: assert property (init_done_out_reg && reg_wr && reg_addr == 8'h18 ##1 !write_locked_reg
		|=> {4'h0, input1_internal_bias_en_reg, input1_termination_en_reg, input0_internal_bias_en_reg,
		input0_termination_en_reg} == ($past(reg_wdata, 2) & 8'h0f)) else $error("receiver config lost");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_reg))
		else $error("read data moved without read");
	unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h13 || reg_addr > 8'h1a) |=> reg_rdata_reg == 8'h00)
		else $error("unmapped read not zero");

	cover property (reg_wr_discarded_reg);
	cover property ($fell(write_locked_reg));
	cover property (input0_rx_off_reg);
endmodule // cmxl_regs_chk

bind cmxl_regs cmxl_regs_chk u_chk (.*);

// *** sim/tb_clock_mux_output_input_lock_regs.sv ***
`timescale 1ns/1ps

module tb_clock_mux_output_input_lock_regs;
	logic clk = 0, rst = 1;
	logic impedance_strap_mid = 0, impedance_strap_high = 0, slew_strap_pin = 0, startup_force_fast = 0;
	logic ref_input0_true_low = 0, ref_input0_comp_low = 0, ref_input1_true_low = 0, ref_input1_comp_low = 0;
	logic input0_present_live = 0, input1_present_live = 0;
	wire reg_wr, reg_rd, reg_wr_discarded_reg, init_done_out_reg, write_locked_reg;
	wire [7:0] reg_addr, reg_wdata, reg_rdata_reg, out_low_z_select_reg, out_primary_z_select_reg, out_edge_speed_reg;
	wire [15:0] out_z_code_reg;
	wire input0_rx_off_reg, input1_rx_off_reg, input0_internal_bias_en_reg, input1_internal_bias_en_reg;
	wire input0_termination_en_reg, input1_termination_en_reg;
	int num_errors = 0, num_checks = 0;
	logic [7:0] q;

	cmxl_regs u_dut (.*);
	cmxl_host u_host (.*);

	always #10 clk = ~clk;

	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task rdc(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, q);
		chk(q, e);
	endtask

	task results;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Reset stands in for a power cycle
	task boot(input logic m, input logic h, input logic s, input logic f);
		@(negedge clk);
		rst = 1;
		{impedance_strap_mid, impedance_strap_high, slew_strap_pin, startup_force_fast} = {m, h, s, f};
		repeat (5) @(negedge clk);
		rst = 0;
		repeat (3) @(negedge clk);
		chk(init_done_out_reg, 1);
	endtask

	task t_strap;
		boot(1, 0, 0, 0);
		chk(out_low_z_select_reg, 8'hff);
		chk(out_primary_z_select_reg, 8'h00);
		chk(out_edge_speed_reg, 8'h00);
		chk(out_z_code_reg, 16'haaaa);
		boot(0, 1, 1, 0);
		chk(out_low_z_select_reg, 8'h00);
		chk(out_primary_z_select_reg, 8'hff);
		chk(out_edge_speed_reg, 8'hff);
		chk(out_z_code_reg, 16'h5555);
		boot(0, 0, 0, 1);
		chk(out_primary_z_select_reg, 8'h00);
		chk(out_edge_speed_reg, 8'hff);
		chk(out_z_code_reg, 16'h0000);
		rdc(8'h17, 8'h94);
		rdc(8'h18, 8'h00);
		rdc(8'h19, 8'h00);
		rdc(8'h1a, 8'h00);
		$display("strap test done");
	endtask

	task t_rw;
		u_host.wr(8'h16, 8'h5a);
		repeat (2) @(negedge clk);
		chk(out_edge_speed_reg, 8'h5a);
		rdc(8'h16, 8'h5a);
		u_host.wr(8'h18, 8'h0f);
		repeat (2) @(negedge clk);
		chk({input1_internal_bias_en_reg, input1_termination_en_reg, input0_internal_bias_en_reg,
			input0_termination_en_reg}, 4'hf);
		{ref_input0_true_low, ref_input0_comp_low, ref_input1_true_low, ref_input1_comp_low} = 4'hf;
		repeat (3) @(negedge clk);
		chk(input0_rx_off_reg, 1);
		chk(input1_rx_off_reg, 1);
		u_host.wr(8'h17, 8'h90);
		rdc(8'h17, 8'h90);
		repeat (3) @(negedge clk);
		chk(input0_rx_off_reg, 0);
		chk(input1_rx_off_reg, 0);
		{ref_input0_true_low, ref_input0_comp_low, ref_input1_true_low, ref_input1_comp_low} = 4'h0;
		u_host.wr(8'h30, 8'hff);
		rdc(8'h30, 8'h00);
		input0_present_live = 1;
		u_host.wr(8'h13, 8'h00);
		repeat (2) @(negedge clk);
		rdc(8'h13, 8'h01);
		$display("read write test done");
	endtask

	task t_loss;
		input1_present_live = 1;
		@(negedge clk);
		{input0_present_live, input1_present_live} = 2'h0;
		repeat (2) @(negedge clk);
		rdc(8'h1a, 8'h06);
		u_host.wr(8'h1a, 8'h00);
		rdc(8'h1a, 8'h06);
		u_host.wr(8'h1a, 8'h02);
		rdc(8'h1a, 8'h04);
		u_host.wr(8'h1a, 8'h04);
		rdc(8'h1a, 8'h00);
		// Loss lands on the same edge as the clear write
		input1_present_live = 1;
		@(negedge clk);
		fork
			u_host.wr(8'h1a, 8'h04);
			begin
				@(negedge clk);
				input1_present_live = 0;
			end
		join
		rdc(8'h1a, 8'h04);
		u_host.wr(8'h1a, 8'h04);
		rdc(8'h1a, 8'h00);
		$display("loss test done");
	endtask

	task t_lock;
		u_host.wr(8'h1a, 8'h01);
		repeat (2) @(negedge clk);
		chk(write_locked_reg, 1);
		u_host.wr(8'h16, 8'hff);
		rdc(8'h16, 8'h5a);
		u_host.wr(8'h1a, 8'h00);
		rdc(8'h1a, 8'h01);
		u_host.wr(8'h1a, 8'h01);
		rdc(8'h1a, 8'h00);
		u_host.wr(8'h19, 8'h01);
		repeat (2) @(negedge clk);
		chk(write_locked_reg, 1);
		u_host.wr(8'h19, 8'h00);
		u_host.wr(8'h16, 8'h00);
		rdc(8'h19, 8'h01);
		rdc(8'h16, 8'h5a);
		boot(0, 0, 0, 0);
		rdc(8'h19, 8'h00);
		$display("lock test done");
	endtask

	initial begin
		t_strap;
		t_rw;
		t_loss;
		t_lock;
		results;
	end

	initial begin
		#100000;
		num_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		results;
	end
endmodule // tb_clock_mux_output_input_lock_regs
